// [hw/fault_report_consts.svh]
// constants for the fault report and masking block
`ifndef FAULT_REPORT_CONSTS_SVH
`define FAULT_REPORT_CONSTS_SVH

// ************************************************
// channel count and timing
// ************************************************
`define FRM_CHANNELS          16
`define FRM_SYS_CLK_MHZ       25
`define FRM_ERR_PULSE_TIME_US 50
// 50 us at 25 MHz divides exactly, so no rounding is needed
`define FRM_ERR_PULSE_CYCLES  (`FRM_ERR_PULSE_TIME_US * `FRM_SYS_CLK_MHZ)
`define FRM_ERR_CNT_W         11

// ************************************************
// reset values
// ************************************************
`define FRM_FLAG_RESET        1'h0
`define FRM_ERR_N_RESET       1'h1

`endif

// [hw/fault_report_pkg.sv]
// types for the fault report and masking block
package fault_report_pkg;

  // one-hot states of the error pin pulse generator
  typedef enum logic [1:0] {
    PULSE_IDLE = 2'h1,
    PULSE_LOW  = 2'h2
  } pulse_state_t;

endpackage

// [hw/err_pulse_gen.sv]
// one-shot low pulse generator for the open-drain error pin
`timescale 1ns/1ps
`include "fault_report_consts.svh"

module err_pulse_gen #(
  parameter int                      CNT_W        = `FRM_ERR_CNT_W,
  parameter logic [CNT_W-1:0]        PULSE_CYCLES = CNT_W'(`FRM_ERR_PULSE_CYCLES)
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // trigger from unmasked fault events
  input  wire logic trigger,
  // open-drain pin, registered
  output logic      err_n_out,
  output logic      err_n_oe
);

  fault_report_pkg::pulse_state_t state;
  fault_report_pkg::pulse_state_t next_state;
  logic [CNT_W-1:0]               cnt;
  logic [CNT_W-1:0]               next_cnt;
  logic                           next_err_n_out;
  logic                           next_err_n_oe;

  // ************************************************
  // pulse sequencing
  // ************************************************
  // a trigger while the pulse runs is dropped: one pulse per burst of events
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_err_n_out = err_n_out;
    next_err_n_oe  = err_n_oe;
    case (state)
      fault_report_pkg::PULSE_IDLE: begin
        if (trigger) begin
          next_state     = fault_report_pkg::PULSE_LOW;
          next_cnt       = PULSE_CYCLES - CNT_W'(1);
          next_err_n_out = 1'h0;
          next_err_n_oe  = 1'h1;
        end
      end
      fault_report_pkg::PULSE_LOW: begin
        if (cnt == '0) begin
          next_state     = fault_report_pkg::PULSE_IDLE;
          next_err_n_out = 1'h1;
          next_err_n_oe  = 1'h0;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      default: begin
        next_state     = fault_report_pkg::PULSE_IDLE;
        next_cnt       = '0;
        next_err_n_out = 1'h1;
        next_err_n_oe  = 1'h0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state     <= fault_report_pkg::PULSE_IDLE;
      cnt       <= '0;
      err_n_out <= `FRM_ERR_N_RESET;
      err_n_oe  <= 1'h0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      err_n_out <= next_err_n_out;
      err_n_oe  <= next_err_n_oe;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  // helper: length of the current low pulse
  logic [CNT_W-1:0] low_len;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_len <= '0;
    end else begin
      low_len <= err_n_oe ? low_len + CNT_W'(1) : '0;
    end
  end

  property p_pulse_length;
    @(posedge sys_clk) disable iff (rst)
      $fell(err_n_oe) |-> ($past(low_len) == PULSE_CYCLES - CNT_W'(1));
  endproperty
  a_pulse_length: assert property (p_pulse_length) else $error("error pulse length wrong");

  property p_oe_tracks_low;
    @(posedge sys_clk) disable iff (rst)
      err_n_oe == !err_n_out;
  endproperty
  a_oe_tracks_low: assert property (p_oe_tracks_low) else $error("error pin enable mismatch");

endmodule // err_pulse_gen

// [hw/fault_report_masking.sv]
// fault flag latching, masking and error reporting
// How it works
// - Masking never stops detection or flag setting and only hides faults from the summary, global flag and pin.
// - Faults are masked per channel and per fault type, and each mask alone blocks reporting.
// - A channel with diagnostics disabled sets no flag of its own, no summary flag and no pin pulse.
// - A masked low-supply warning sets its flag but leaves the global flag and the pin alone.
// - An unmasked low-supply warning sets its flag and the global flag and pulls the pin low once for 50 us.
// - Flags stay latched until the host writes the clear command, which drops back to 0 on its own.
`timescale 1ns/1ps
`include "fault_report_consts.svh"

module fault_report_masking #(
  parameter int N = `FRM_CHANNELS
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // detector outputs, already deglitched on sys_clk
  input  wire logic [N-1:0] open_detect,
  input  wire logic [N-1:0] short_detect,
  input  wire logic [N-1:0] single_led_short_detect,
  input  wire logic         low_supply_detect,
  // configuration
  input  wire logic [N-1:0] channel_diag_enable,
  input  wire logic [N-1:0] channel_report_mask,
  input  wire logic         open_mask,
  input  wire logic         short_mask,
  input  wire logic         single_led_short_mask,
  input  wire logic         low_supply_mask,
  // host clear request, one cycle per write of 1
  input  wire logic         clear_fault_write,
  // flags, all registered
  output logic [N-1:0]      channel_open_flag,
  output logic [N-1:0]      channel_short_flag,
  output logic [N-1:0]      channel_single_led_short_flag,
  output logic              low_supply_flag,
  output logic              out_flag,
  output logic              err_flag,
  output logic              clear_fault_cmd,
  // open-drain error pin
  output logic              err_n_out,
  output logic              err_n_oe
);

  // latched flag update: a new fault wins over a clear in the same cycle
  function automatic logic [N-1:0] latch_next(input logic [N-1:0] cur, input logic [N-1:0] set,
                                              input logic clr);
    latch_next = set | (cur & ~{N{clr}});
  endfunction

  // ************************************************
  // detection and reporting terms
  // ************************************************
  logic [N-1:0] open_seen;
  logic [N-1:0] short_seen;
  logic [N-1:0] sls_seen;
  logic [N-1:0] open_rep;
  logic [N-1:0] short_rep;
  logic [N-1:0] sls_rep;
  logic         low_rep;
  logic         chan_rep_any;
  logic [3*N:0] rep_vec;
  logic [3*N:0] rep_prev;
  logic         new_event;

  // diag enable gates detection itself; masks gate only reporting
  always_comb begin
    open_seen    = open_detect & channel_diag_enable;
    short_seen   = short_detect & channel_diag_enable;
    sls_seen     = single_led_short_detect & channel_diag_enable;
    open_rep     = open_seen & ~channel_report_mask & ~{N{open_mask}};
    short_rep    = short_seen & ~channel_report_mask & ~{N{short_mask}};
    sls_rep      = sls_seen & ~channel_report_mask & ~{N{single_led_short_mask}};
    low_rep      = low_supply_detect & !low_supply_mask;
    chan_rep_any = |{open_rep, short_rep, sls_rep};
    rep_vec      = {open_rep, short_rep, sls_rep, low_rep};
    // only a fresh unmasked condition starts a pulse; a standing fault does not repeat
    new_event    = |(rep_vec & ~rep_prev);
  end

  // ************************************************
  // flag state
  // ************************************************
  logic [N-1:0] next_channel_open_flag;
  logic [N-1:0] next_channel_short_flag;
  logic [N-1:0] next_channel_single_led_short_flag;
  logic         next_low_supply_flag;
  logic         next_out_flag;
  logic         next_err_flag;
  logic         next_clear_fault_cmd;
  logic [3*N:0] next_rep_prev;

  // next flag values; the clear bit self-clears one cycle after the write
  always_comb begin
    next_channel_open_flag             = latch_next(channel_open_flag, open_seen, clear_fault_cmd);
    next_channel_short_flag            = latch_next(channel_short_flag, short_seen, clear_fault_cmd);
    next_channel_single_led_short_flag = latch_next(channel_single_led_short_flag, sls_seen,
                                                    clear_fault_cmd);
    next_low_supply_flag = low_supply_detect | (low_supply_flag & !clear_fault_cmd);
    next_out_flag        = chan_rep_any | (out_flag & !clear_fault_cmd);
    next_err_flag        = chan_rep_any | low_rep | (err_flag & !clear_fault_cmd);
    next_clear_fault_cmd = clear_fault_write;
    next_rep_prev        = rep_vec;
  end

  // flag registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      channel_open_flag             <= '0;
      channel_short_flag            <= '0;
      channel_single_led_short_flag <= '0;
      low_supply_flag               <= `FRM_FLAG_RESET;
      out_flag                      <= `FRM_FLAG_RESET;
      err_flag                      <= `FRM_FLAG_RESET;
      clear_fault_cmd               <= 1'h0;
      rep_prev                      <= '0;
    end else begin
      channel_open_flag             <= next_channel_open_flag;
      channel_short_flag            <= next_channel_short_flag;
      channel_single_led_short_flag <= next_channel_single_led_short_flag;
      low_supply_flag               <= next_low_supply_flag;
      out_flag                      <= next_out_flag;
      err_flag                      <= next_err_flag;
      clear_fault_cmd               <= next_clear_fault_cmd;
      rep_prev                      <= next_rep_prev;
    end
  end

  // ************************************************
  // error pin
  // ************************************************
  // pulse generator, triggered only by unmasked events
  err_pulse_gen #(
    .CNT_W        (`FRM_ERR_CNT_W),
    .PULSE_CYCLES (`FRM_ERR_CNT_W'(`FRM_ERR_PULSE_CYCLES))
  ) err_pulse_gen_inst (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .trigger   (new_event),
    .err_n_out (err_n_out),
    .err_n_oe  (err_n_oe)
  );

  // ************************************************
  // checks
  // ************************************************
  property p_masked_flag_kept;
    @(posedge sys_clk) disable iff (rst)
      ((open_detect & channel_diag_enable) != '0) |=>
        (($past(open_detect) & $past(channel_diag_enable) & ~channel_open_flag) == '0);
  endproperty
  a_masked_flag_kept: assert property (p_masked_flag_kept) else $error("open flag not set");

  property p_chan_mask_blocks;
    @(posedge sys_clk) disable iff (rst)
      (!out_flag && (((open_seen | short_seen | sls_seen) & ~channel_report_mask) == '0)) |=> !out_flag;
  endproperty
  a_chan_mask_blocks: assert property (p_chan_mask_blocks) else $error("masked channel reported");

  property p_diag_off_no_flag;
    @(posedge sys_clk) disable iff (rst)
      ((~$past(channel_diag_enable) & ~$past(channel_open_flag) & channel_open_flag) |
       (~$past(channel_diag_enable) & ~$past(channel_short_flag) & channel_short_flag) |
       (~$past(channel_diag_enable) & ~$past(channel_single_led_short_flag) & channel_single_led_short_flag)) == '0;
  endproperty
  a_diag_off_no_flag: assert property (p_diag_off_no_flag) else $error("disabled channel flagged");

  property p_low_masked;
    @(posedge sys_clk) disable iff (rst)
      (low_supply_detect && low_supply_mask && !err_flag && !chan_rep_any) |=> (low_supply_flag && !err_flag);
  endproperty
  a_low_masked: assert property (p_low_masked) else $error("masked low supply misreported");

  property p_low_unmasked;
    @(posedge sys_clk) disable iff (rst)
      (low_supply_detect && !low_supply_mask && !rep_prev[0] && err_n_out) |=> (err_flag && low_supply_flag)
        ##1 !err_n_out;
  endproperty
  a_low_unmasked: assert property (p_low_unmasked) else $error("low supply not reported");

  property p_clear_self_returns;
    @(posedge sys_clk) disable iff (rst)
      (clear_fault_cmd && !clear_fault_write) |=> !clear_fault_cmd;
  endproperty
  a_clear_self_returns: assert property (p_clear_self_returns) else $error("clear bit stuck");

  property p_clear_flags;
    @(posedge sys_clk) disable iff (rst)
      (clear_fault_cmd && !low_supply_detect && !chan_rep_any) |=> (!err_flag && !low_supply_flag);
  endproperty
  a_clear_flags: assert property (p_clear_flags) else $error("flags not cleared");

  property p_pulse_cause;
    @(posedge sys_clk) disable iff (rst)
      $fell(err_n_out) |-> $past(new_event);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without unmasked event");

  // a type mask alone must keep the summary low, whatever the channel mask says
  property p_type_mask_blocks;
    @(posedge sys_clk) disable iff (rst)
      (!out_flag && (((open_seen & ~{N{open_mask}}) | (short_seen & ~{N{short_mask}}) |
                      (sls_seen & ~{N{single_led_short_mask}})) == '0)) |=> !out_flag;
  endproperty
  a_type_mask_blocks: assert property (p_type_mask_blocks) else $error("type masked fault reported");

  property p_summary_set;
    @(posedge sys_clk) disable iff (rst)
      chan_rep_any |=> (out_flag && err_flag);
  endproperty
  a_summary_set: assert property (p_summary_set) else $error("reported fault missing in summary");

  property p_low_flag_set;
    @(posedge sys_clk) disable iff (rst)
      low_supply_detect |=> low_supply_flag;
  endproperty
  a_low_flag_set: assert property (p_low_flag_set) else $error("low supply flag not set");

  property p_global_low;
    @(posedge sys_clk) disable iff (rst)
      low_rep |=> err_flag;
  endproperty
  a_global_low: assert property (p_global_low) else $error("unmasked low supply not global");

  // the clear bit shows for exactly the cycle after the host write
  property p_clear_follows;
    @(posedge sys_clk) disable iff (rst)
      clear_fault_write |=> clear_fault_cmd;
  endproperty
  a_clear_follows: assert property (p_clear_follows) else $error("clear bit not raised");

endmodule // fault_report_masking

// [testbench/host_model.sv]
// host controller model: watches the error pin and writes the clear bit
`timescale 1ns/1ps

module host_model (
  // clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rst,
  // open-drain error pin of the device
  input  wire logic   err_n_out,
  input  wire logic   err_n_oe,
  // clear bit write strobe
  output logic        clear_fault_write,
  // pulse observations
  output logic [15:0] pulse_count,
  output logic [15:0] last_width
);
  logic        err_pin;
  logic [15:0] low_cycles;

  // pull-up keeps the pin high whenever the device lets go
  assign err_pin = err_n_oe ? err_n_out : 1'b1;

  // measure each low pulse in whole clock cycles
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pulse_count <= 16'h0000;
      last_width  <= 16'h0000;
      low_cycles  <= 16'h0000;
    end else if (!err_pin) begin
      low_cycles <= low_cycles + 16'h0001;
    end else if (low_cycles != 16'h0000) begin
      pulse_count <= pulse_count + 16'h0001;
      last_width  <= low_cycles;
      low_cycles  <= 16'h0000;
    end
  end

  // one write of 1 to the clear bit, seen as a single-cycle strobe
  task automatic write_clear();
    @(posedge sys_clk);
    clear_fault_write <= 1'b1;
    @(posedge sys_clk);
    clear_fault_write <= 1'b0;
  endtask

  initial clear_fault_write = 1'b0;
endmodule // host_model

// [testbench/fault_report_masking_bench.sv]
// self-checking bench for the fault report and masking block
`timescale 1ns/1ps
`include "fault_report_consts.svh"

module fault_report_masking_bench;
  logic        sys_clk, rst, low_supply_detect, clear_fault_write;
  logic        open_mask, short_mask, single_led_short_mask, low_supply_mask;
  logic [15:0] open_detect, short_detect, single_led_short_detect;
  logic [15:0] channel_diag_enable, channel_report_mask;
  logic [15:0] channel_open_flag, channel_short_flag, channel_single_led_short_flag;
  logic        low_supply_flag, out_flag, err_flag, clear_fault_cmd, err_n_out, err_n_oe;
  logic [15:0] pulse_count, last_width;
  int          num_errors, samples_checked;

  fault_report_masking #(.N(16)) fault_report_masking_inst (.sys_clk(sys_clk), .rst(rst),
    .open_detect(open_detect), .short_detect(short_detect), .single_led_short_detect(single_led_short_detect),
    .low_supply_detect(low_supply_detect), .channel_diag_enable(channel_diag_enable),
    .channel_report_mask(channel_report_mask), .open_mask(open_mask), .short_mask(short_mask),
    .single_led_short_mask(single_led_short_mask), .low_supply_mask(low_supply_mask),
    .clear_fault_write(clear_fault_write), .channel_open_flag(channel_open_flag),
    .channel_short_flag(channel_short_flag), .channel_single_led_short_flag(channel_single_led_short_flag),
    .low_supply_flag(low_supply_flag), .out_flag(out_flag), .err_flag(err_flag),
    .clear_fault_cmd(clear_fault_cmd), .err_n_out(err_n_out), .err_n_oe(err_n_oe));

  host_model host_model_inst (.sys_clk(sys_clk), .rst(rst), .err_n_out(err_n_out), .err_n_oe(err_n_oe),
    .clear_fault_write(clear_fault_write), .pulse_count(pulse_count), .last_width(last_width));

  // ************************************************
  // compare and closing tasks
  // ************************************************
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_vec(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // drop every detector, then clear through the host and expect all flags low
  task automatic clear_all();
    @(posedge sys_clk);
    open_detect <= 16'h0000;
    short_detect <= 16'h0000;
    single_led_short_detect <= 16'h0000;
    low_supply_detect <= 1'b0;
    host_model_inst.write_clear();
    #1;
    check_bit(clear_fault_cmd, 1'b1);
    @(posedge sys_clk);
    #1;
    check_bit(clear_fault_cmd, 1'b0);
    check_vec(channel_open_flag | channel_short_flag | channel_single_led_short_flag, 16'h0000);
    check_bit(low_supply_flag | out_flag | err_flag, 1'b0);
  endtask

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_low_supply(input logic mask);
    logic [15:0] base;
    base = pulse_count;
    @(posedge sys_clk);
    low_supply_mask <= mask;
    low_supply_detect <= 1'b1;
    @(posedge sys_clk);
    #1;
    check_bit(low_supply_flag, 1'b1);
    check_bit(err_flag, ~mask);
    check_bit(err_n_oe, ~mask);
    check_bit(err_n_out, mask);
    repeat (1300) @(posedge sys_clk);
    check_vec(pulse_count - base, {15'h0000, ~mask});
    if (!mask) check_vec(last_width, 16'(`FRM_ERR_PULSE_CYCLES));
    clear_all();
    low_supply_mask <= 1'b0;
  endtask

  // channel 3 disabled: all three detectors fire there, nothing may show
  task automatic t_diag_off();
    logic [15:0] base;
    base = pulse_count;
    @(posedge sys_clk);
    channel_diag_enable <= 16'hFFF7;
    open_detect <= 16'h0008;
    short_detect <= 16'h0008;
    single_led_short_detect <= 16'h0008;
    @(posedge sys_clk);
    #1;
    check_vec(channel_open_flag | channel_short_flag | channel_single_led_short_flag, 16'h0000);
    check_bit(out_flag | err_flag, 1'b0);
    repeat (1300) @(posedge sys_clk);
    check_vec(pulse_count - base, 16'h0000);
    // re-enable only once the detectors are low, or the channel would fire a late pulse
    clear_all();
    channel_diag_enable <= 16'hFFFF;
  endtask

  // type masks hide every fault, channel 5 also under the channel mask, and each flag still sets
  task automatic t_masks();
    logic [15:0] base;
    base = pulse_count;
    @(posedge sys_clk);
    channel_report_mask <= 16'h0020;
    open_mask <= 1'b1;
    short_mask <= 1'b1;
    single_led_short_mask <= 1'b1;
    short_detect <= 16'h0060;
    open_detect <= 16'h0100;
    single_led_short_detect <= 16'h0001;
    @(posedge sys_clk);
    #1;
    check_vec(channel_short_flag, 16'h0060);
    check_vec(channel_open_flag, 16'h0100);
    check_vec(channel_single_led_short_flag, 16'h0001);
    check_bit(out_flag | err_flag, 1'b0);
    repeat (1300) @(posedge sys_clk);
    check_vec(pulse_count - base, 16'h0000);
    // unmask only after the detectors drop, so no pulse leaks into the next scenario
    clear_all();
    channel_report_mask <= 16'h0000;
    open_mask <= 1'b0;
    short_mask <= 1'b0;
    single_led_short_mask <= 1'b0;
  endtask

  // unmasked standing fault: one pulse only, and a clear cannot beat it
  task automatic t_open_standing();
    logic [15:0] base;
    base = pulse_count;
    @(posedge sys_clk);
    short_mask <= 1'b1;
    open_detect <= 16'h0002;
    @(posedge sys_clk);
    #1;
    check_bit(out_flag & err_flag & err_n_oe, 1'b1);
    host_model_inst.write_clear();
    @(posedge sys_clk);
    #1;
    check_vec(channel_open_flag, 16'h0002);
    repeat (1300) @(posedge sys_clk);
    check_vec(pulse_count - base, 16'h0001);
    // fault gone but no clear yet: flags must stay latched
    open_detect <= 16'h0000;
    short_mask <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    check_vec(channel_open_flag, 16'h0002);
    check_bit(out_flag & err_flag, 1'b1);
    clear_all();
  endtask

  // clock runs at 25 MHz
  always #20 sys_clk = ~sys_clk;

  // main sequence
  initial begin
    {sys_clk, rst, low_supply_detect, open_mask, short_mask, single_led_short_mask, low_supply_mask} = 7'h20;
    {open_detect, short_detect, single_led_short_detect, channel_report_mask} = 64'h0;
    channel_diag_enable = 16'hFFFF;
    num_errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    check_bit(err_flag | low_supply_flag | out_flag | clear_fault_cmd | err_n_oe, 1'b0);
    check_bit(err_n_out, 1'b1);
    t_low_supply(1'b1);
    t_low_supply(1'b0);
    t_diag_off();
    t_masks();
    t_open_standing();
    end_of_test();
  end

  // watchdog: the scenarios need under 8000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    end_of_test();
  end
endmodule // fault_report_masking_bench
